// ---- tsc_clk_startup.sv ----
`timescale 1ns/1ns
module tsc_clk_startup import tsc_pkg::*; #(
  parameter int WARM_NS = WARM_DEF_NS,
  parameter int P_PLL_LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_ext_osc,
  input wire logic i_por_done,
  input wire logic i_sleep,
  input wire logic i_wake,
  input wire logic [2:0] i_osc_mode_cfg,
  input wire logic i_two_speed_switchover_cfg,
  input wire logic i_watchdog_timer_en,
  input wire logic i_fail_safe_clock_monitor_en,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  output logic [2:0] o_sys_clk_sel,
  output logic o_osc_startup_timer_en,
  output logic o_ext_osc_stable_flag,
  output logic o_low_freq_internal_osc_en,
  output logic o_pll_active,
  output logic o_sleeping,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Types and timing
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_HALT      = 8'h01,
    ST_TWO_SPEED = 8'h02,
    ST_OST       = 8'h04,
    ST_WARM      = 8'h08,
    ST_INT_START = 8'h10,
    ST_SYNC      = 8'h20,
    ST_PLL       = 8'h40,
    ST_RUN       = 8'h80
  } tsc_state_e;

  localparam int WARM_CYC_I = (WARM_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [DLY_W-1:0] WARM_LD = DLY_W'((WARM_CYC_I < 1) ? 1 : WARM_CYC_I);
  localparam logic [DLY_W-1:0] INT_START_LD = DLY_W'(INT_START_CYC);
  localparam logic [DLY_W-1:0] PLL_LD = DLY_W'(P_PLL_LOCK_CYC);
  localparam logic [DLY_W-1:0] SYNC_LD = DLY_W'(SYNC_CYC);
  localparam logic [DLY_W-1:0] SLEEP_EXT_LD = DLY_W'(SLEEP_EXT_CYC);
  localparam logic [OST_W-1:0] OST_LD = OST_W'(OST_COUNT);

  // ----------------------------------------------------------------
  // External oscillation synchroniser and edge detect
  // ----------------------------------------------------------------
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_edge;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_osc;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_edge = ext_s2_q & ~ext_s3_q;

  // ----------------------------------------------------------------
  // Registers visible to software
  // ----------------------------------------------------------------
  logic [DW-1:0] ctrl_q;
  logic [DW-1:0] ctrl_d;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_mask_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [IRQ_W-1:0] irq_evt;
  logic [DW-1:0] stat_word;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  tsc_state_e state_q;
  tsc_state_e state_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [2:0] tgt_q;
  logic [2:0] tgt_d;
  logic stable_q;
  logic stable_d;
  logic pll_on_q;
  logic pll_on_d;
  logic por_q;
  logic lf_en_q;
  logic lf_en_d;
  logic ost_en_q;
  logic sleeping_q;
  logic dly_load;
  logic [DLY_W-1:0] dly_val;
  logic dly_zero;
  logic ost_load;
  logic ost_zero;
  logic start_evt;
  logic two_speed_ok;
  logic [2:0] tgt_now;

  assign start_evt = (i_por_done & ~por_q) | i_wake;
  assign tgt_now = target_src(ctrl_q[CTRL_CSS_LSB +: 2], ctrl_q[CTRL_IFS_LSB +: 4],
                              i_osc_mode_cfg);
  assign two_speed_ok = i_two_speed_switchover_cfg && (ctrl_q[CTRL_CSS_LSB +: 2] == CSS_CONFIG)
                        && is_crystal(i_osc_mode_cfg);

  tsc_delay_cnt #(.W(DLY_W)) u_dly (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(dly_load),
    .i_load_val(dly_val),
    .i_tick(1'b1),
    .o_zero(dly_zero)
  );

  tsc_delay_cnt #(.W(OST_W)) u_ost (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(ost_load),
    .i_load_val(OST_LD),
    .i_tick(ext_edge),
    .o_zero(ost_zero)
  );

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    tgt_d = tgt_q;
    stable_d = stable_q;
    pll_on_d = pll_on_q;
    dly_load = 1'b0;
    dly_val = SYNC_LD;
    ost_load = 1'b0;
    irq_evt = '0;
    case (state_q)
      ST_HALT: begin
        if (start_evt) begin
          tgt_d = tgt_now;
          stable_d = 1'b0;
          if (two_speed_ok) begin
            sel_d = SRC_HF;
            ost_load = 1'b1;
            state_d = ST_TWO_SPEED;
          end else if ((tgt_now == SRC_CRYSTAL) || (tgt_now == SRC_SECONDARY)) begin
            ost_load = 1'b1;
            state_d = ST_OST;
          end else if (tgt_now == SRC_EXT_CLK) begin
            dly_load = 1'b1;
            dly_val = SLEEP_EXT_LD;
            state_d = ST_SYNC;
          end else begin
            dly_load = 1'b1;
            dly_val = WARM_LD;
            state_d = ST_WARM;
          end
        end
      end
      ST_TWO_SPEED: begin
        if (ost_zero) begin
          stable_d = 1'b1;
          sel_d = tgt_q;
          irq_evt[IRQ_STABLE_BIT] = 1'b1;
          irq_evt[IRQ_SWITCH_BIT] = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_OST: begin
        if (ost_zero) begin
          stable_d = 1'b1;
          sel_d = tgt_q;
          irq_evt[IRQ_STABLE_BIT] = 1'b1;
          irq_evt[IRQ_SWITCH_BIT] = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_WARM, ST_INT_START: begin
        if (dly_zero) begin
          dly_load = 1'b1;
          dly_val = SYNC_LD;
          state_d = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (dly_zero) begin
          sel_d = tgt_q;
          irq_evt[IRQ_SWITCH_BIT] = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_PLL: begin
        if (!ctrl_q[CTRL_PLL_BIT]) begin
          state_d = ST_RUN;
        end else if (dly_zero) begin
          pll_on_d = 1'b1;
          irq_evt[IRQ_SWITCH_BIT] = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pll_on_q && !ctrl_q[CTRL_PLL_BIT]) begin
          pll_on_d = 1'b0;
        end
        if (tgt_now != sel_q) begin
          tgt_d = tgt_now;
          if ((tgt_now == SRC_CRYSTAL) || (tgt_now == SRC_SECONDARY)) begin
            ost_load = 1'b1;
            state_d = ST_OST;
          end else if ((tgt_now == SRC_HF) || (tgt_now == SRC_MF)) begin
            dly_load = 1'b1;
            dly_val = INT_START_LD;
            state_d = ST_INT_START;
          end else begin
            dly_load = 1'b1;
            dly_val = SYNC_LD;
            state_d = ST_SYNC;
          end
        end else if (ctrl_q[CTRL_PLL_BIT] && !pll_on_q) begin
          dly_load = 1'b1;
          dly_val = PLL_LD;
          state_d = ST_PLL;
        end
      end
      default: begin
        state_d = ST_HALT;
      end
    endcase
    if (i_sleep && (state_q != ST_HALT)) begin
      if (state_q == ST_TWO_SPEED) begin
        irq_evt[IRQ_ABORT_BIT] = 1'b1;
      end
      irq_evt[IRQ_STABLE_BIT] = 1'b0;
      irq_evt[IRQ_SWITCH_BIT] = 1'b0;
      stable_d = 1'b0;
      sel_d = sel_q;
      pll_on_d = 1'b0;
      dly_load = 1'b0;
      ost_load = 1'b0;
      state_d = ST_HALT;
    end
  end

  always_comb begin
    lf_en_d = (sel_d == SRC_LF) || (tgt_d == SRC_LF) || i_watchdog_timer_en
              || i_fail_safe_clock_monitor_en;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_HALT;
      sel_q <= SRC_RST;
      tgt_q <= SRC_RST;
      stable_q <= 1'b0;
      pll_on_q <= 1'b0;
      por_q <= 1'b0;
      lf_en_q <= 1'b0;
      ost_en_q <= 1'b0;
      sleeping_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      tgt_q <= tgt_d;
      stable_q <= stable_d;
      pll_on_q <= pll_on_d;
      por_q <= i_por_done;
      lf_en_q <= lf_en_d;
      ost_en_q <= (state_d == ST_TWO_SPEED) || (state_d == ST_OST);
      sleeping_q <= (state_d == ST_HALT);
    end
  end

  // ----------------------------------------------------------------
  // Register access and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    stat_word = '0;
    stat_word[STAT_STABLE_BIT] = stable_q;
    stat_word[STAT_PLL_BIT] = pll_on_q;
    stat_word[STAT_LF_BIT] = lf_en_q;
    stat_word[STAT_TWO_SPEED_BIT] = (state_q == ST_TWO_SPEED);
    stat_word[STAT_SRC_LSB +: 3] = sel_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    rdata_d = '0;
    if (i_wr && (i_addr == OFS_CTRL)) begin
      ctrl_d = i_wdata;
    end
    if (i_wr && (i_addr == OFS_IRQ_MASK)) begin
      irq_mask_d = i_wdata[IRQ_W-1:0];
    end
    if (i_wr && (i_addr == OFS_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~i_wdata[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL: rdata_d = ctrl_q;
        OFS_STAT: rdata_d = stat_word;
        OFS_IRQ_STAT: rdata_d = {{(DW-IRQ_W){1'b0}}, irq_stat_q};
        OFS_IRQ_MASK: rdata_d = {{(DW-IRQ_W){1'b0}}, irq_mask_q};
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RST;
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_sys_clk_sel = sel_q;
  assign o_osc_startup_timer_en = ost_en_q;
  assign o_ext_osc_stable_flag = stable_q;
  assign o_low_freq_internal_osc_en = lf_en_q;
  assign o_pll_active = pll_on_q;
  assign o_sleeping = sleeping_q;
  assign o_irq = irq_q;

endmodule // tsc_clk_startup

// ---- tsc_pkg.sv ----
package tsc_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int AW = 4;
  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_STAT = 4'h1;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 4'h3;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_CSS_LSB = 0;
  localparam int CTRL_IFS_LSB = 2;
  localparam int CTRL_PLL_BIT = 6;
  localparam logic [DW-1:0] CTRL_RST = 8'h00;
  localparam int STAT_STABLE_BIT = 0;
  localparam int STAT_PLL_BIT = 1;
  localparam int STAT_LF_BIT = 2;
  localparam int STAT_TWO_SPEED_BIT = 3;
  localparam int STAT_SRC_LSB = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_STABLE_BIT = 0;
  localparam int IRQ_SWITCH_BIT = 1;
  localparam int IRQ_ABORT_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ----------------------------------------------------------------
  // Oscillator modes and clock sources
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;
  localparam logic [2:0] MODE_EXT_CLK = 3'h3;
  localparam logic [2:0] MODE_RC = 3'h4;
  localparam logic [1:0] CSS_CONFIG = 2'h0;
  localparam logic [1:0] CSS_SECONDARY = 2'h1;
  localparam logic [3:0] IFS_LF = 4'h0;
  localparam logic [3:0] IFS_MF_MAX = 4'h7;
  localparam logic [2:0] SRC_CRYSTAL = 3'h0;
  localparam logic [2:0] SRC_HF = 3'h1;
  localparam logic [2:0] SRC_MF = 3'h2;
  localparam logic [2:0] SRC_LF = 3'h3;
  localparam logic [2:0] SRC_EXT_CLK = 3'h4;
  localparam logic [2:0] SRC_SECONDARY = 3'h5;
  localparam logic [2:0] SRC_RST = SRC_HF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OST_W = 11;
  localparam int OST_COUNT = 1024;
  localparam int DLY_W = 17;
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int INT_START_NS = 2000;
  localparam int INT_START_CYC = (INT_START_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int PLL_LOCK_NS = 2000000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int WARM_DEF_NS = 2000;
  localparam int SYNC_CYC = 2;
  localparam int SLEEP_EXT_CYC = 2;

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == MODE_LP) || (mode == MODE_XT) || (mode == MODE_HS);
  endfunction

  function automatic logic [2:0] int_src(input logic [3:0] ifs);
    if (ifs == IFS_LF) begin
      int_src = SRC_LF;
    end else if (ifs <= IFS_MF_MAX) begin
      int_src = SRC_MF;
    end else begin
      int_src = SRC_HF;
    end
  endfunction

  function automatic logic [2:0] target_src(input logic [1:0] css, input logic [3:0] ifs,
                                            input logic [2:0] mode);
    if (css == CSS_CONFIG) begin
      if (is_crystal(mode)) begin
        target_src = SRC_CRYSTAL;
      end else if ((mode == MODE_EXT_CLK) || (mode == MODE_RC)) begin
        target_src = SRC_EXT_CLK;
      end else begin
        target_src = int_src(ifs);
      end
    end else if (css == CSS_SECONDARY) begin
      target_src = SRC_SECONDARY;
    end else begin
      target_src = int_src(ifs);
    end
  endfunction

endpackage

// ---- tsc_delay_cnt.sv ----
`timescale 1ns/1ns
module tsc_delay_cnt #(
  parameter int W = 11
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_tick,
  output logic o_zero
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_load) begin
      cnt_d = i_load_val;
    end else if (i_tick && (cnt_q != '0)) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_zero = (cnt_q == '0);

endmodule // tsc_delay_cnt

// ---- tsc_xtal_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Crystal model: it stands still low while stopped.
// ----------------------------------------------------------------
module tsc_xtal_model #(
  parameter int HALF_NS = 37
) (
  input wire logic i_run,
  output logic o_osc
);
  initial o_osc = 1'b0;
  always begin
    #(HALF_NS);
    o_osc = i_run ? ~o_osc : 1'b0;
  end
endmodule // tsc_xtal_model

// ---- tsc_clk_startup_properties.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module tsc_clk_startup_chk import tsc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_ext_osc,
  input wire logic i_por_done,
  input wire logic i_sleep,
  input wire logic i_wake,
  input wire logic [2:0] i_osc_mode_cfg,
  input wire logic i_two_speed_switchover_cfg,
  input wire logic i_watchdog_timer_en,
  input wire logic i_fail_safe_clock_monitor_en,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DW-1:0] o_rdata,
  input wire logic [2:0] o_sys_clk_sel,
  input wire logic o_osc_startup_timer_en,
  input wire logic o_ext_osc_stable_flag,
  input wire logic o_low_freq_internal_osc_en,
  input wire logic o_pll_active,
  input wire logic o_sleeping,
  input wire logic o_irq
);
  logic [1:0] css_q, css_d;
  logic [2:0] msk_q, msk_d;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  always_comb begin
    css_d = css_q;
    msk_d = msk_q;
    if (i_wr && i_addr == OFS_CTRL) css_d = i_wdata[1:0];
    if (i_wr && i_addr == OFS_IRQ_MASK) msk_d = i_wdata[IRQ_W-1:0];
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      css_q <= 2'h0;
      msk_q <= 3'h0;
    end else begin
      css_q <= css_d;
      msk_q <= msk_d;
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  stable_switch_a: assert property ($rose(o_ext_osc_stable_flag) |-> !o_osc_startup_timer_en &&
    (o_sys_clk_sel == SRC_CRYSTAL || o_sys_clk_sel == SRC_SECONDARY))
    else $error("stable flag set without switch");
  count_done_a: assert property ($fell(o_osc_startup_timer_en) && !o_sleeping
    |-> o_ext_osc_stable_flag) else $error("count ended without stable flag");
  sleep_abort_a: assert property (i_sleep && !o_sleeping |=> o_sleeping &&
    !o_ext_osc_stable_flag && !o_osc_startup_timer_en) else $error("sleep did not abort");
  two_speed_hf_a: assert property ($rose(o_osc_startup_timer_en) && $past(o_sleeping) &&
    i_two_speed_switchover_cfg && css_q == CSS_CONFIG |-> o_sys_clk_sel == SRC_HF)
    else $error("two-speed start not on internal clock");
  crystal_wait_a: assert property (o_osc_startup_timer_en && !i_two_speed_switchover_cfg
    |-> $stable(o_sys_clk_sel)) else $error("source changed during count");
  no_count_a: assert property (o_sleeping && i_wake && i_osc_mode_cfg > MODE_HS &&
    css_q == CSS_CONFIG |=> !o_osc_startup_timer_en [*3]) else $error("count in non-crystal mode");
  irq_mask_a: assert property (msk_q == 3'h0 && $past(msk_q) == 3'h0 && $past(msk_q, 2) == 3'h0
    |-> !o_irq) else $error("interrupt while fully masked");
  lf_keep_a: assert property ($past(i_watchdog_timer_en || i_fail_safe_clock_monitor_en) &&
    $past(i_arst_n) |-> o_low_freq_internal_osc_en) else $error("low-freq osc off while needed");
  halt_hold_a: assert property (o_sleeping && !i_wake && !i_por_done |=> o_sleeping)
    else $error("left halt without start");
  cover property ($rose(o_ext_osc_stable_flag));
  cover property (i_sleep && o_osc_startup_timer_en);
  cover property ($rose(o_pll_active));
endmodule // tsc_clk_startup_chk

bind tsc_clk_startup tsc_clk_startup_chk u_chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
  .i_ext_osc(i_ext_osc), .i_por_done(i_por_done), .i_sleep(i_sleep), .i_wake(i_wake),
  .i_osc_mode_cfg(i_osc_mode_cfg), .i_two_speed_switchover_cfg(i_two_speed_switchover_cfg),
  .i_watchdog_timer_en(i_watchdog_timer_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_fail_safe_clock_monitor_en(i_fail_safe_clock_monitor_en), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_sys_clk_sel(o_sys_clk_sel), .o_pll_active(o_pll_active),
  .o_osc_startup_timer_en(o_osc_startup_timer_en), .o_ext_osc_stable_flag(o_ext_osc_stable_flag),
  .o_low_freq_internal_osc_en(o_low_freq_internal_osc_en), .o_sleeping(o_sleeping), .o_irq(o_irq));

// ---- tb_tsc_clk_startup.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb_tsc_clk_startup import tsc_pkg::*; ();
  typedef struct packed {logic [2:0] mode; logic cfg; logic osc_startup_timer; logic [2:0] fin; logic st;} tsc_row_s;
  logic i_sys_clk = 1'b0;
  logic i_arst_n, i_ext_osc, i_por_done, i_sleep, i_wake, i_two_speed_switchover_cfg;
  logic i_watchdog_timer_en, i_fail_safe_clock_monitor_en, i_wr, i_rd;
  logic [2:0] i_osc_mode_cfg, o_sys_clk_sel, prev;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic o_osc_startup_timer_en, o_ext_osc_stable_flag, o_low_freq_internal_osc_en;
  logic o_pll_active, o_sleeping, o_irq;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  tsc_row_s rows [6] = '{{MODE_LP, 1'b1, 1'b1, SRC_CRYSTAL, 1'b1},
    {MODE_EXT_CLK, 1'b1, 1'b0, SRC_EXT_CLK, 1'b0},
    {MODE_HS, 1'b0, 1'b1, SRC_CRYSTAL, 1'b1}, {MODE_RC, 1'b1, 1'b0, SRC_EXT_CLK, 1'b0},
    {MODE_XT, 1'b1, 1'b1, SRC_CRYSTAL, 1'b1}, {3'h5, 1'b1, 1'b0, SRC_LF, 1'b0}};

  always #10 i_sys_clk = ~i_sys_clk;

  tsc_xtal_model xtal (.i_run(!o_sleeping), .o_osc(i_ext_osc));
  tsc_clk_startup #(.WARM_NS(100), .P_PLL_LOCK_CYC(20)) dut (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_ext_osc(i_ext_osc), .i_por_done(i_por_done), .i_sleep(i_sleep),
    .i_wake(i_wake), .i_osc_mode_cfg(i_osc_mode_cfg), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_two_speed_switchover_cfg(i_two_speed_switchover_cfg), .i_wr(i_wr), .i_rd(i_rd),
    .i_watchdog_timer_en(i_watchdog_timer_en), .o_rdata(o_rdata), .o_sys_clk_sel(o_sys_clk_sel),
    .i_fail_safe_clock_monitor_en(i_fail_safe_clock_monitor_en), .o_irq(o_irq),
    .o_osc_startup_timer_en(o_osc_startup_timer_en), .o_ext_osc_stable_flag(o_ext_osc_stable_flag),
    .o_low_freq_internal_osc_en(o_low_freq_internal_osc_en), .o_pll_active(o_pll_active),
    .o_sleeping(o_sleeping));

  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic pulse(input bit s);
    @(posedge i_sys_clk);
    if (s) i_sleep <= 1'b1;
    else i_wake <= 1'b1;
    @(posedge i_sys_clk);
    i_sleep <= 1'b0;
    i_wake <= 1'b0;
  endtask
  task automatic wt(input logic [2:0] s);
    #1 n = 0;
    while ((o_sys_clk_sel !== s || o_osc_startup_timer_en !== 1'b0) && n < 6000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {i_arst_n, i_por_done, i_sleep, i_wake, i_wr, i_rd} = 6'h00;
    {i_watchdog_timer_en, i_fail_safe_clock_monitor_en, i_addr, i_wdata} = 14'h0000;
    i_two_speed_switchover_cfg = 1'b1;
    i_osc_mode_cfg = MODE_XT;
    cyc(3);
    `CHK(o_sys_clk_sel, SRC_RST)
    i_arst_n <= 1'b1;
    rd(OFS_CTRL); `CHK(d, CTRL_RST)
    rd(OFS_IRQ_MASK); `CHK(d, 8'h00)
    wr(OFS_STAT, 8'hff);
    rd(OFS_STAT); `CHK(d & 8'h71, {1'b0, SRC_RST, 4'h0})
    rd(4'hf); `CHK(d, 8'h00)
    wr(OFS_CTRL, 8'h80);
    rd(OFS_CTRL); `CHK(d, 8'h80)
    wr(OFS_CTRL, 8'h00);
    @(posedge i_sys_clk) i_por_done <= 1'b1;
    cyc(2);
    `CHK({o_sleeping, o_sys_clk_sel, o_osc_startup_timer_en}, {1'b0, SRC_HF, 1'b1})
    wt(SRC_CRYSTAL); `CHK(o_ext_osc_stable_flag, 1'b1)
    prev = SRC_CRYSTAL;
    foreach (rows[k]) begin
      pulse(1);
      i_osc_mode_cfg <= rows[k].mode;
      i_two_speed_switchover_cfg <= rows[k].cfg;
      pulse(0);
      cyc(1);
      `CHK(o_osc_startup_timer_en, rows[k].osc_startup_timer)
      if (rows[k].osc_startup_timer) `CHK(o_sys_clk_sel, rows[k].cfg ? SRC_HF : prev)
      wt(rows[k].fin); `CHK(o_sys_clk_sel, rows[k].fin)
      `CHK(o_ext_osc_stable_flag, rows[k].st)
      prev = rows[k].fin;
    end
    wr(OFS_CTRL, 8'h22); wt(SRC_HF); `CHK(n inside {[98:110]}, 1'b1)
    wr(OFS_CTRL, 8'h02); wt(SRC_LF); `CHK(n inside {[1:6]}, 1'b1)
    `CHK(o_low_freq_internal_osc_en, 1'b1)
    wr(OFS_CTRL, 8'h06); wt(SRC_MF); `CHK(n inside {[98:110]}, 1'b1)
    cyc(3); `CHK(o_low_freq_internal_osc_en, 1'b0)
    i_fail_safe_clock_monitor_en <= 1'b1;
    cyc(3); `CHK(o_low_freq_internal_osc_en, 1'b1)
    i_fail_safe_clock_monitor_en <= 1'b0;
    wr(OFS_CTRL, 8'h46);
    for (n = 0; o_pll_active !== 1'b1 && n < 100; n++) cyc(1);
    `CHK(n inside {[18:30]}, 1'b1)
    wr(OFS_CTRL, 8'h06); cyc(3); `CHK(o_pll_active, 1'b0)
    pulse(1);
    wr(OFS_CTRL, 8'h22);
    pulse(0); wt(SRC_HF); `CHK(n inside {[4:15]}, 1'b1)
    wr(OFS_IRQ_STAT, 8'h07);
    wr(OFS_IRQ_MASK, 8'h05);
    wr(OFS_CTRL, 8'h00);
    i_osc_mode_cfg <= MODE_XT;
    pulse(1);
    pulse(0);
    cyc(100); `CHK(o_osc_startup_timer_en, 1'b1)
    pulse(1); cyc(1);
    `CHK({o_sleeping, o_ext_osc_stable_flag, o_osc_startup_timer_en}, 3'h4)
    cyc(2); `CHK(o_irq, 1'b1)
    rd(OFS_IRQ_STAT); `CHK(d & 8'h04, 8'h04)
    wr(OFS_IRQ_STAT, 8'h07); cyc(3); `CHK(o_irq, 1'b0)
    pulse(0); wt(SRC_CRYSTAL); `CHK(o_ext_osc_stable_flag, 1'b1)
    cyc(3); `CHK(o_irq, 1'b1)
    wrap_up();
  end
endmodule // tb_tsc_clk_startup
